// [logic/hpsc_slot_ctrl.sv]
`timescale 1ns/1ps
// Contract
// - Bits 0-3 enable button, fault, latch, presence interrupts or wake events.
// - Bit 12 enables interrupt or wake on link-active change.
// - Bit 4 enables command-complete interrupt only, never a wake.
// - Bit 5 is the master interrupt enable for all enabled events.
// - Fields without their capability read zero and ignore writes.
// - Bits 7:6 drive attention indicator; 1 on, 2 blink, 3 off; reset off.
// - Attention field reads zero without attention-indicator capability.
// - Bits 9:8 drive power indicator, same codes, reset on.
// - Power indicator field reads zero without power-indicator capability.
// - On the upstream port power indicator writes change no indicator.
// - Bit 10 sets slot power; 0 on, 1 off; reset on.
// - One write is one command; completion flagged after all actions finish. Writes made while a command runs share one queued command.
// - Each event sets its own status flag; writing one clears it.
// - Capability bits decide which control fields exist and are writable; the link-active enable, bit 12, exists whatever the capability.
module hpsc_slot_ctrl (
    input wire logic clk,
    input wire logic reset,
    input wire logic [11:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic upstream_port,
    input wire logic link_active,
    input wire logic btn_pin,
    input wire logic fault_pin,
    input wire logic latch_pin,
    input wire logic presence_pin,
    input wire logic ext_ack_pin,
    output logic [1:0] attention_led_ctrl,
    output logic [1:0] power_led_ctrl,
    output logic slot_power_ctrl,
    output logic interlock,
    output logic ext_req,
    output logic irq,
    output logic wake
);
    // Mask of control fields that exist for a given capability word
    function automatic logic [15:0] ctrl_mask(input logic [31:0] cap);
        logic [15:0] m;
        m = '0;
        m[hpsc_pkg::CTL_BTN] = cap[hpsc_pkg::CAP_BTN];
        m[hpsc_pkg::CTL_FLT] = cap[hpsc_pkg::CAP_PWR];
        m[hpsc_pkg::CTL_LATCH] = cap[hpsc_pkg::CAP_LATCH];
        m[hpsc_pkg::CTL_PRES] = cap[hpsc_pkg::CAP_HP];
        m[hpsc_pkg::CTL_CMD_DONE_IRQ_ENABLE] = cap[hpsc_pkg::CAP_HP];
        m[hpsc_pkg::CTL_MASTER] = cap[hpsc_pkg::CAP_HP];
        m[hpsc_pkg::CTL_ATTN +: 2] = {2{cap[hpsc_pkg::CAP_ATTN]}};
        m[hpsc_pkg::CTL_PLED +: 2] = {2{cap[hpsc_pkg::CAP_PLED]}};
        m[hpsc_pkg::CTL_PWR] = cap[hpsc_pkg::CAP_PWR];
        m[hpsc_pkg::CTL_ILK] = cap[hpsc_pkg::CAP_ILK];
        m[hpsc_pkg::CTL_DLL] = 1'b1;
        return m;
    endfunction

    hpsc_cmd_if cif ();

    logic [31:0] cap_q;
    logic [15:0] ctl_q;
    logic [15:0] ctl_eff;
    logic [15:0] wmask;
    logic [5:0] st_q;
    logic [5:0] st_set;
    logic [5:0] st_clr;
    logic [5:0] ien_q;
    logic [5:0] en_sel;
    logic [5:0] wake_sel;
    logic [3:0] pin_lvl;
    logic [3:0] pin_rise;
    logic [3:0] pin_chg;
    logic la_q;
    logic start_q;
    logic wr_ctl;
    logic [31:0] rd_val;

    // Pin events through synchronisers
    hpsc_evt #(
        .N(4)
    ) u_evt (
        .clk(clk),
        .reset(reset),
        .pin({presence_pin, latch_pin, fault_pin, btn_pin}),
        .level(pin_lvl),
        .rise(pin_rise),
        .change(pin_chg)
    );

    // Command sequencer toward the slot expander
    hpsc_cmd u_cmd (
        .clk(clk),
        .reset(reset),
        .cif(cif),
        .ack_pin(ext_ack_pin),
        .ext_req(ext_req)
    );

    // Decode and effective control view
    assign wr_ctl = wr && addr == hpsc_pkg::OFF_CTRL;
    assign wmask = ctrl_mask(cap_q) & hpsc_pkg::CTL_STORE;
    assign ctl_eff = ctl_q & ctrl_mask(cap_q);

    // Capability register, written by firmware
    always_ff @(posedge clk)
    begin
        if (reset)
            cap_q <= hpsc_pkg::CAP_RST;
        else if (wr && addr == hpsc_pkg::OFF_CAP)
            cap_q <= wdata & hpsc_pkg::CAP_WMASK;
    end

    // Slot control storage; missing fields keep their value
    always_ff @(posedge clk)
    begin
        if (reset)
            ctl_q <= hpsc_pkg::CTL_RST;
        else if (wr_ctl)
            ctl_q <= (wdata[15:0] & wmask) | (ctl_q & ~wmask);
    end

    // One write raises one start pulse toward the sequencer
    always_ff @(posedge clk)
    begin
        if (reset)
            start_q <= 1'b0;
        else
            start_q <= wr_ctl;
    end
    assign cif.start = start_q;

    // Indicator and power drive
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            attention_led_ctrl <= hpsc_pkg::LED_OFF;
            power_led_ctrl <= hpsc_pkg::LED_ON;
            slot_power_ctrl <= 1'b0;
        end
        else
        begin
            attention_led_ctrl <= ctl_q[hpsc_pkg::CTL_ATTN +: 2];
            if (!upstream_port)
                power_led_ctrl <= ctl_q[hpsc_pkg::CTL_PLED +: 2];
            slot_power_ctrl <= ctl_q[hpsc_pkg::CTL_PWR];
        end
    end

    // Interlock toggles on a written one
    always_ff @(posedge clk)
    begin
        if (reset)
            interlock <= 1'b0;
        else if (wr_ctl && wdata[hpsc_pkg::CTL_ILK] && cap_q[hpsc_pkg::CAP_ILK])
            interlock <= ~interlock;
    end

    // Link-active edge detect; follows the link in reset so release adds no change
    always_ff @(posedge clk)
    begin
        if (reset)
            la_q <= link_active;
        else
            la_q <= link_active;
    end

    // Sticky status; a set beats a same-cycle clear
    assign st_set = {link_active ^ la_q, cif.done, pin_chg[3:2], pin_rise[1:0]};
    assign st_clr = (wr && addr == hpsc_pkg::OFF_CLR) ? wdata[5:0] : 6'h00;
    always_ff @(posedge clk)
    begin
        if (reset)
            st_q <= 6'h00;
        else
            st_q <= (st_q & ~st_clr) | st_set;
    end

    // Interrupt enable register
    always_ff @(posedge clk)
    begin
        if (reset)
            ien_q <= hpsc_pkg::IEN_RST;
        else if (wr && addr == hpsc_pkg::OFF_IEN)
            ien_q <= wdata[5:0];
    end

    // Per-event gating
    assign en_sel = {ctl_eff[hpsc_pkg::CTL_DLL], ctl_eff[hpsc_pkg::CTL_CMD_DONE_IRQ_ENABLE],
        ctl_eff[hpsc_pkg::CTL_PRES:hpsc_pkg::CTL_BTN]};
    assign wake_sel = en_sel & 6'h2F;

    // Interrupt and wake outputs
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            irq <= 1'b0;
            wake <= 1'b0;
        end
        else
        begin
            irq <= ctl_eff[hpsc_pkg::CTL_MASTER] && |(st_q & en_sel & ien_q);
            wake <= |(st_q & wake_sel);
        end
    end

    // Read multiplexer
    always_comb
    begin
        rd_val = 32'h0000_0000;
        unique case (addr)
            hpsc_pkg::OFF_CAP: rd_val = cap_q;
            hpsc_pkg::OFF_CTRL: rd_val = {16'h0000, ctl_q & wmask};
            hpsc_pkg::OFF_STAT:
            begin
                rd_val[5:0] = st_q;
                rd_val[hpsc_pkg::ST_LVL +: 4] = {cif.busy, interlock, pin_lvl[3:2]};
            end
            hpsc_pkg::OFF_IEN: rd_val = {26'h0000000, ien_q};
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (reset)
            rdata <= 32'h0000_0000;
        else
            rdata <= rd ? rd_val : 32'h0000_0000;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_ctl_read;
        rd && addr == hpsc_pkg::OFF_CTRL;
    endsequence

    a_btn_irq:
    assert property ((st_q[0] && ctl_eff[0] && ien_q[0] && ctl_eff[hpsc_pkg::CTL_MASTER])
        |=> irq)
        else $error("button event did not raise interrupt");
    a_dll_irq:
    assert property ((link_active != la_q) ##1 (ctl_eff[hpsc_pkg::CTL_DLL] && ien_q[5]
        && ctl_eff[hpsc_pkg::CTL_MASTER]) |=> irq)
        else $error("link change did not raise interrupt");
    a_cc_nowake:
    assert property ((st_q & 6'h2F) == 6'h00 |=> !wake)
        else $error("wake from command completion");
    a_irq_master:
    assert property (!ctl_eff[hpsc_pkg::CTL_MASTER] |=> !irq)
        else $error("interrupt with master enable clear");
    a_write_mask:
    assert property (wr_ctl && !cap_q[hpsc_pkg::CAP_PWR] |=> $stable(ctl_q[hpsc_pkg::CTL_PWR]))
        else $error("write reached a missing field");
    a_attn_drive:
    assert property (wr_ctl && cap_q[hpsc_pkg::CAP_ATTN] |=> ##1
        attention_led_ctrl == $past(wdata[7:6], 2))
        else $error("attention indicator not set by write");
    a_attn_zero:
    assert property (s_ctl_read and !cap_q[hpsc_pkg::CAP_ATTN] |=> rdata[7:6] == 2'h0)
        else $error("attention field not zero");
    a_pled_zero:
    assert property (s_ctl_read and !cap_q[hpsc_pkg::CAP_PLED] |=> rdata[9:8] == 2'h0)
        else $error("power indicator field not zero");
    a_upstream_pled:
    assert property (upstream_port |=> $stable(power_led_ctrl))
        else $error("power indicator moved on upstream port");
    a_ilk_toggle:
    assert property (wr_ctl && wdata[11] && cap_q[hpsc_pkg::CAP_ILK]
        |=> interlock != $past(interlock))
        else $error("interlock did not toggle");
    a_rsv_zero:
    assert property (s_ctl_read |=> rdata[15:13] == 3'h0 && !rdata[hpsc_pkg::CTL_ILK])
        else $error("reserved control bits not zero");
    a_cc_status:
    assert property (cif.done |=> st_q[hpsc_pkg::ST_CC])
        else $error("completion flag not set");
    a_st_clear:
    assert property (st_clr[0] && !st_set[0] |=> !st_q[0])
        else $error("status flag not cleared");
    a_pled_drive:
    assert property (wr_ctl && cap_q[hpsc_pkg::CAP_PLED] ##1 !upstream_port
        |=> power_led_ctrl == $past(wdata[9:8], 2))
        else $error("power indicator not set by write");
    a_power_drive:
    assert property (wr_ctl && cap_q[hpsc_pkg::CAP_PWR] |=> ##1
        slot_power_ctrl == $past(wdata[hpsc_pkg::CTL_PWR], 2))
        else $error("slot power not set by write");
    a_start_once:
    assert property (wr_ctl |=> cif.start)
        else $error("control write did not start a command");
    a_set_wins:
    assert property (st_set != 6'h00 |=> (st_q & $past(st_set)) == $past(st_set))
        else $error("status event lost");
    a_wake_event:
    assert property ((st_q & wake_sel) != 6'h00 |=> wake)
        else $error("enabled event did not raise wake");
    a_reset_values:
    assert property ($past(reset) |-> attention_led_ctrl == hpsc_pkg::LED_OFF
        && power_led_ctrl == hpsc_pkg::LED_ON && !slot_power_ctrl && !interlock)
        else $error("outputs not at reset values");
endmodule

// [logic/hpsc_pkg.sv]
package hpsc_pkg;
    // Register byte offsets
    localparam logic [11:0] OFF_CAP = 12'h054;
    localparam logic [11:0] OFF_CTRL = 12'h058;
    localparam logic [11:0] OFF_STAT = 12'h060;
    localparam logic [11:0] OFF_CLR = 12'h064;
    localparam logic [11:0] OFF_IEN = 12'h068;

    // Slot control field positions
    localparam int CTL_BTN = 0;
    localparam int CTL_FLT = 1;
    localparam int CTL_LATCH = 2;
    localparam int CTL_PRES = 3;
    localparam int CTL_CMD_DONE_IRQ_ENABLE = 4;
    localparam int CTL_MASTER = 5;
    localparam int CTL_ATTN = 6;
    localparam int CTL_PLED = 8;
    localparam int CTL_PWR = 10;
    localparam int CTL_ILK = 11;
    localparam int CTL_DLL = 12;

    // Slot capability bit positions
    localparam int CAP_BTN = 0;
    localparam int CAP_PWR = 1;
    localparam int CAP_LATCH = 2;
    localparam int CAP_ATTN = 3;
    localparam int CAP_PLED = 4;
    localparam int CAP_HP = 6;
    localparam int CAP_ILK = 17;

    // Status and enable layout
    localparam int EVT_N = 6;
    localparam int ST_CC = 4;
    localparam int ST_DLL = 5;
    localparam int ST_LVL = 8;

    // Indicator codes
    localparam logic [1:0] LED_ON = 2'h1;
    localparam logic [1:0] LED_BLINK = 2'h2;
    localparam logic [1:0] LED_OFF = 2'h3;

    // Values after reset, store and write masks, synchroniser depth
    localparam logic [15:0] CTL_RST = 16'h01C0;
    localparam logic [15:0] CTL_STORE = 16'h17FF;
    localparam logic [31:0] CAP_RST = 32'h0000_0000;
    localparam logic [31:0] CAP_WMASK = 32'hFFFB_FFFF;
    localparam logic [5:0] IEN_RST = 6'h3F;
    localparam int SYNC_N = 3;

    typedef enum logic [1:0] {CMD_IDLE, CMD_REQ, CMD_REL} hpsc_cmd_e;
endpackage

// [logic/hpsc_cmd_if.sv]
`timescale 1ns/1ps
interface hpsc_cmd_if;
    logic start;
    logic done;
    logic busy;
    modport ctl (output start, input done, input busy);
    modport seq (input start, output done, output busy);
endinterface

// [logic/hpsc_evt.sv]
`timescale 1ns/1ps
module hpsc_evt #(
    parameter int N = 4
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [N-1:0] pin,
    output logic [N-1:0] level,
    output logic [N-1:0] rise,
    output logic [N-1:0] change
);
    if (N < 1)
    begin : g_bad
        $error("hpsc_evt needs at least one pin");
    end

    localparam int FILL_W = $clog2(hpsc_pkg::SYNC_N + 1);

    logic [FILL_W-1:0] fill_q;
    logic filled;

    // Edges since reset until every stage holds a real pin sample
    always_ff @(posedge clk)
    begin
        if (reset)
            fill_q <= '0;
        else if (!filled)
            fill_q <= fill_q + FILL_W'(1);
    end

    // Reset zeros agree too; loading them would fake an event later
    assign filled = fill_q == FILL_W'(hpsc_pkg::SYNC_N);

    for (genvar i = 0; i < N; i++)
    begin : g_pin
        logic [hpsc_pkg::SYNC_N-1:0] s_q;
        logic lvl_q;
        logic armed_q;
        logic agree;

        // Three-stage synchroniser
        always_ff @(posedge clk)
        begin
            if (reset)
                s_q <= '0;
            else
                s_q <= {s_q[1:0], pin[i]};
        end

        assign agree = s_q[1] == s_q[2];

        // Filtered level; first agreement after the fill loads silently
        always_ff @(posedge clk)
        begin
            if (reset)
            begin
                lvl_q <= 1'b0;
                armed_q <= 1'b0;
            end
            else if (agree && filled)
            begin
                lvl_q <= s_q[2];
                armed_q <= 1'b1;
            end
        end

        assign level[i] = lvl_q;
        assign change[i] = armed_q && agree && (s_q[2] != lvl_q);
        assign rise[i] = change[i] && s_q[2];
    end
endmodule

// [logic/hpsc_cmd.sv]
`timescale 1ns/1ps
module hpsc_cmd (
    input wire logic clk,
    input wire logic reset,
    hpsc_cmd_if.seq cif,
    input wire logic ack_pin,
    output logic ext_req
);
    hpsc_pkg::hpsc_cmd_e state_q, state_d;
    logic [hpsc_pkg::SYNC_N-1:0] as_q;
    logic ack_q;
    logic pend_q;
    logic done_q;

    // Acknowledge synchroniser and filter
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            as_q <= '0;
            ack_q <= 1'b0;
        end
        else
        begin
            as_q <= {as_q[1:0], ack_pin};
            if (as_q[1] == as_q[2])
                ack_q <= as_q[2];
        end
    end

    // Request, wait for acknowledge, then for its release
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            hpsc_pkg::CMD_IDLE: if (cif.start) state_d = hpsc_pkg::CMD_REQ;
            hpsc_pkg::CMD_REQ: if (ack_q) state_d = hpsc_pkg::CMD_REL;
            hpsc_pkg::CMD_REL:
                if (!ack_q)
                    state_d = (pend_q || cif.start) ? hpsc_pkg::CMD_REQ : hpsc_pkg::CMD_IDLE;
        endcase
    end

    // State, pending write and completion pulse
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_q <= hpsc_pkg::CMD_IDLE;
            pend_q <= 1'b0;
            done_q <= 1'b0;
            ext_req <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            ext_req <= state_d == hpsc_pkg::CMD_REQ;
            done_q <= state_q == hpsc_pkg::CMD_REL && state_d == hpsc_pkg::CMD_IDLE;
            if (cif.start && (state_q == hpsc_pkg::CMD_REQ
                || (state_q == hpsc_pkg::CMD_REL && ack_q)))
                pend_q <= 1'b1;
            else if (state_q == hpsc_pkg::CMD_REL && !ack_q)
                pend_q <= 1'b0;
        end
    end

    assign cif.done = done_q;
    assign cif.busy = state_q != hpsc_pkg::CMD_IDLE;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_release;
        state_q == hpsc_pkg::CMD_REL && !ack_q && !pend_q && !cif.start;
    endsequence
    sequence s_handshake;
        ext_req ##1 (state_q == hpsc_pkg::CMD_REL);
    endsequence

    a_cmd_done:
    assert property (s_release |=> done_q ##1 !done_q)
        else $error("command completion not signalled once");
    a_done_cause:
    assert property (done_q |-> $past(state_q) == hpsc_pkg::CMD_REL && !ext_req)
        else $error("completion without finished handshake");
    a_req_hold:
    assert property (s_handshake |-> !ext_req)
        else $error("request not dropped after acknowledge");
endmodule

// [tb/hpsc_slot_hw.sv]
`timescale 1ns/1ps
// Slot expander stand-in: acknowledges each request after a chosen delay
module hpsc_slot_hw (
    input wire logic clk,
    input wire logic reset,
    input wire logic ext_req,
    input wire logic [7:0] ack_delay,
    output logic ext_ack_pin
);
    int cnt;

    // Ack rises after req, falls after req falls, each after the delay
    always @(posedge clk)
    begin
        if (reset)
        begin
            ext_ack_pin <= 1'b0;
            cnt <= 0;
        end
        else if (ext_ack_pin == ext_req)
            cnt <= 0;
        else if (cnt >= ack_delay)
        begin
            ext_ack_pin <= ext_req;
            cnt <= 0;
        end
        else
            cnt <= cnt + 1;
    end
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
// Self-checking bench for the slot control register bank
module testbench;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic up = 1'b0;
    logic link = 1'b0;
    logic [3:0] pins = 4'h0;
    logic [7:0] dly = 8'h02;
    logic [31:0] rdata;
    logic [1:0] att;
    logic [1:0] pled;
    logic ack, spwr, ilk, req, irq, wake;
    logic [31:0] seed = 32'h67C2;
    int errors = 0;
    int total_checks = 0;
    int cm, cp, st, ien, il, po;

    always #5 clk = ~clk;

    hpsc_slot_ctrl i_hpsc_slot_ctrl (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .upstream_port(up), .link_active(link),
        .btn_pin(pins[0]), .fault_pin(pins[1]), .latch_pin(pins[2]),
        .presence_pin(pins[3]), .ext_ack_pin(ack), .attention_led_ctrl(att),
        .power_led_ctrl(pled), .slot_power_ctrl(spwr), .interlock(ilk), .ext_req(req),
        .irq(irq), .wake(wake));

    hpsc_slot_hw i_hpsc_slot_hw (.clk(clk), .reset(reset), .ext_req(req),
        .ack_delay(dly), .ext_ack_pin(ack));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Control bits visible and writable for a capability set
    function automatic int gm(int c);
        int m;
        m = 32'h1000;
        if (c[0]) m = m | 32'h1;
        if (c[1]) m = m | 32'h402;
        if (c[2]) m = m | 32'h4;
        if (c[3]) m = m | 32'hC0;
        if (c[4]) m = m | 32'h300;
        if (c[6]) m = m | 32'h38;
        return m;
    endfunction

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(logic [31:0] got, logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Register write, with the model following it
    task automatic wreg(logic [11:0] a, logic [31:0] d);
        int m;
        m = gm(cp);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        if (a == hpsc_pkg::OFF_CAP) cp = d & hpsc_pkg::CAP_WMASK;
        if (a == hpsc_pkg::OFF_CLR) st = st & ~int'(d[5:0]);
        if (a == hpsc_pkg::OFF_IEN) ien = d[5:0];
        if (a == hpsc_pkg::OFF_CTRL)
        begin
            cm = (cm & ~m) | (d & m);
            il = il ^ (d[11] & cp[17]);
            if (!up) po = cm[9:8];
        end
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rreg(logic [11:0] a, output logic [31:0] v);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
        @(posedge clk);
    endtask

    task automatic rchk(logic [11:0] a, logic [31:0] e);
        logic [31:0] v;
        rreg(a, v);
        chk(v, e);
    endtask

    // Outputs against the model: indicators, power, interlock, irq, wake, idle request
    task automatic chk_out();
        int m, en;
        m = gm(cp) & cm;
        en = {m[12], m[4:0]};
        #1;
        chk({att, pled, spwr, ilk, irq, wake, req}, {cm[7:6], po[1:0], cm[10], il[0],
            m[5] & |(st & en & ien), |(st & en & 32'h2F), 1'b0});
        @(posedge clk);
    endtask

    task automatic wait_cmd();
        logic [31:0] v;
        v = 32'h0;
        for (int i = 0; i < 100 && !v[4]; i++)
            rreg(hpsc_pkg::OFF_STAT, v);
        if (!v[4])
        begin
            errors++;
            tally_and_finish();
        end
        st = st | 32'h10;
    endtask

    // One control command, checked to completion and cleared
    task automatic wctl(logic [31:0] d);
        logic [31:0] v;
        wreg(hpsc_pkg::OFF_CTRL, d);
        wait_cmd();
        chk_out();
        rchk(hpsc_pkg::OFF_CTRL, cm & gm(cp));
        rreg(hpsc_pkg::OFF_STAT, v);
        chk(v & 32'h43F, st | (il << 10));
        wreg(hpsc_pkg::OFF_CLR, 32'h10);
        chk_out();
    endtask

    task automatic model_reset();
        cm = hpsc_pkg::CTL_RST;
        cp = 0;
        st = 0;
        ien = 32'h3F;
        il = 0;
        po = 1;
    endtask

    initial
    begin
        repeat (100000) @(posedge clk);
        errors++;
        tally_and_finish();
    end

    initial
    begin
        logic [31:0] v;
        model_reset();
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        chk_out();
        rchk(hpsc_pkg::OFF_CTRL, 32'h0);
        rchk(hpsc_pkg::OFF_IEN, 32'h3F);
        wctl(32'hFFFF);
        wreg(hpsc_pkg::OFF_CAP, 32'h0006005F);
        rchk(hpsc_pkg::OFF_CAP, cp);
        wreg(12'h070, xs());
        rchk(12'h070, 32'h0);
        for (int k = 0; k < 8; k++)
            wctl((xs() & 32'hFC3F) | ((k % 4) << 6) | (((k + 1) % 4) << 8));
        up <= 1'b1;
        @(posedge clk);
        wctl(cm ^ 32'h300);
        up <= 1'b0;
        dly <= 8'h14;
        @(posedge clk);
        wreg(hpsc_pkg::OFF_CTRL, cm | 32'h103F);
        wreg(hpsc_pkg::OFF_CTRL, cm);
        repeat (3) @(posedge clk);
        #1 chk(req, 1'b1);
        @(posedge clk);
        rreg(hpsc_pkg::OFF_STAT, v);
        chk(v[4], 1'b0);
        wait_cmd();
        chk_out();
        wreg(hpsc_pkg::OFF_CLR, 32'h10);
        dly <= 8'h02;
        for (int i = 0; i < 4; i++)
        begin
            pins[i] <= 1'b1;
            repeat (8) @(posedge clk);
            st = st | (1 << i);
            chk_out();
        end
        link <= 1'b1;
        repeat (2) @(posedge clk);
        st = st | 32'h20;
        chk_out();
        wreg(hpsc_pkg::OFF_IEN, 32'h0);
        chk_out();
        wreg(hpsc_pkg::OFF_IEN, 32'h3F);
        wctl(cm & ~32'h20);
        wreg(hpsc_pkg::OFF_CLR, 32'h3F);
        chk_out();
        rreg(hpsc_pkg::OFF_STAT, v);
        chk(v & 32'h43F, st | (il << 10));
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        model_reset();
        @(posedge clk);
        chk_out();
        rchk(hpsc_pkg::OFF_CTRL, 32'h0);
        rreg(hpsc_pkg::OFF_STAT, v);
        chk(v & 32'hF3F, 32'h300);
        tally_and_finish();
    end
endmodule
